// *** core/ocpwm_defines.vh ***
// constants for the output compare / pwm channel
// assumes inclusion by the channel module only
`ifndef OCPWM_DEFINES_VH
`define OCPWM_DEFINES_VH

// register offsets (word index on the plain port)
`define OCPWM_ADDR_SEC 4'h0
`define OCPWM_ADDR_MAIN 4'h1
`define OCPWM_ADDR_CTRL 4'h2
`define OCPWM_ADDR_STAT 4'h3

// control register fields
`define OCPWM_MODE_LO 0
`define OCPWM_MODE_HI 2
`define OCPWM_TSEL_BIT 3
`define OCPWM_FLT_BIT 4
`define OCPWM_SIDL_BIT 13
`define OCPWM_CTRL_WMASK 16'h200F

// status register fields
`define OCPWM_STAT_EVT_BIT 0
`define OCPWM_STAT_PIN_BIT 1
`define OCPWM_STAT_ARM_BIT 2

// mode codes
`define OCPWM_M_OFF 3'h0
`define OCPWM_M_LOW 3'h1
`define OCPWM_M_HIGH 3'h2
`define OCPWM_M_TOGGLE 3'h3
`define OCPWM_M_SINGLE 3'h4
`define OCPWM_M_CONT 3'h5
`define OCPWM_M_PWM 3'h6
`define OCPWM_M_PWMF 3'h7

// reset values
`define OCPWM_RST_WORD 16'h0000
`define OCPWM_DUTY_ZERO 16'h0000

`endif

// *** core/ocpwm_channel.v ***
// one output compare / pwm channel with fault shutdown
// assumes: timers live outside; their counts, period-match increments,
// enables and idle-stop bits arrive as synchronous inputs on CLK
// register words: 0 secondary value, 1 main value, 2 control, 3 status
// control: [2:0] mode, [3] timer select, [4] fault flag, [13] idle stop
// status: [0] compare flag (write 1 to clear), [1] pin level, [2] pulse armed
// pwm expects the selected timer to pulse its increment only on rollover
//
// Summary of operation
// - bit 3 picks one of two timers
// - reset selects the first timer
// - modes 1,2,3 force low, high, toggle
// - single match compares main value to count
// - wrap without match leaves pin unchanged
// - modes 4 and 5 are dual-match pulse
// - main starts pulse, secondary ends it
// - pwm modes: main read-only, secondary buffered duty
// - mode 7 low fault input tristates pin
// - fault flag at bit 4 reports fault
// - fault holds until cleared and mode rewritten
// - pwm period follows the external timer period
// - period rollover sets pin, reloads duty, flags timer
// - zero duty stays low, big duty stays high
// - sleep freezes pin and state
// - idle runs only when allowed by bits
// - non-pwm compare events set sticky flag
// - pwm never sets the compare flag
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/100ps
`include "ocpwm_defines.vh"

module ocpwm_channel (
  // clock and reset
  input wire CLK,
  input wire RST,
  // register port
  input wire [3:0] ADDR,
  input wire [15:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [15:0] RDATA,
  // timer a (first timer)
  input wire [15:0] TA_COUNT,
  input wire TA_INC,
  input wire TA_ON,
  input wire TA_SIDL,
  // timer b (second timer)
  input wire [15:0] TB_COUNT,
  input wire TB_INC,
  input wire TB_ON,
  input wire TB_SIDL,
  // cpu power state
  input wire SLEEP,
  input wire IDLE,
  // pins
  input wire FAULT_N,
  output reg OC_OUT,
  output reg OC_OE,
  // events
  output reg EVT_FLAG,
  output reg TA_PERIOD_FLAG,
  output reg TB_PERIOD_FLAG
);

  reg [15:0] sec_q;
  reg [15:0] main_q;
  reg [2:0] mode_q;
  reg tsel_q;
  reg sidl_q;
  reg fault_q;
  reg pin_q;
  reg armed_q;
  reg evt_q;
  reg [15:0] rdata_d;
  reg pin_d;
  reg armed_d;
  reg fault_d;
  reg evt_d;

  wire [15:0] cnt;
  wire inc;
  wire run;
  wire ctrl_wr;
  wire evt_clr;
  wire is_pwm;
  wire is_dual;
  wire match_main;
  wire match_sec;
  wire period_end;
  wire duty_hit;
  wire idle_go;
  wire evt_hit;
  wire oe_d;

  // ----------------------------------------
  // shared decodes
  // ----------------------------------------
  // write strobe aimed at one register word
  function wr_hit;
    input [3:0] sel;
    begin
      wr_hit = WR && (ADDR == sel);
    end
  endfunction

  function mode_pwm;
    input [2:0] m;
    begin
      mode_pwm = (m == `OCPWM_M_PWM) || (m == `OCPWM_M_PWMF);
    end
  endfunction

  function mode_dual;
    input [2:0] m;
    begin
      mode_dual = (m == `OCPWM_M_SINGLE) || (m == `OCPWM_M_CONT);
    end
  endfunction

  // a timer lets the channel run in idle only while on and not idle-stopped
  function idle_ok;
    input on;
    input stop;
    begin
      idle_ok = on && !stop;
    end
  endfunction

  // ----------------------------------------
  // time base and run gating
  // ----------------------------------------
  assign cnt = tsel_q ? TB_COUNT : TA_COUNT;
  assign inc = tsel_q ? TB_INC : TA_INC;
  // idle keeps running only with the channel and selected-timer stop bits clear and the selected timer on
  assign idle_go = tsel_q ? idle_ok(TB_ON, TB_SIDL) : idle_ok(TA_ON, TA_SIDL);
  assign run = !SLEEP && (!IDLE || (!sidl_q && idle_go));

  assign ctrl_wr = wr_hit(`OCPWM_ADDR_CTRL);
  assign evt_clr = wr_hit(`OCPWM_ADDR_STAT) && WDATA[`OCPWM_STAT_EVT_BIT];
  assign is_pwm = mode_pwm(mode_q);
  assign is_dual = mode_dual(mode_q);
  // a match is acted upon on the increment that leaves the matching count
  assign match_main = run && inc && (cnt == main_q);
  assign match_sec = run && inc && (cnt == sec_q);
  // the external timer clears itself on this same increment
  assign period_end = run && inc && is_pwm;
  // pwm duty compare is a level compare against the working latch
  assign duty_hit = run && is_pwm && (cnt == main_q);
  // every non-pwm compare event raises the sticky flag
  assign evt_hit = (mode_q != `OCPWM_M_OFF) && !is_pwm && (match_main || (is_dual && match_sec));
  assign oe_d = (mode_q != `OCPWM_M_OFF) && !fault_q;

  // ----------------------------------------
  // register file
  // ----------------------------------------
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      sec_q <= `OCPWM_RST_WORD;
      mode_q <= `OCPWM_M_OFF;
      tsel_q <= 1'b0;
      sidl_q <= 1'b0;
    end else if (WR) begin
      if (ADDR == `OCPWM_ADDR_SEC) begin
        sec_q <= WDATA;
      end
      if (ctrl_wr) begin
        mode_q <= WDATA[`OCPWM_MODE_HI:`OCPWM_MODE_LO];
        tsel_q <= WDATA[`OCPWM_TSEL_BIT];
        sidl_q <= WDATA[`OCPWM_SIDL_BIT];
      end
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always @* begin
    rdata_d = `OCPWM_RST_WORD;
    case (ADDR)
      `OCPWM_ADDR_SEC: begin
        rdata_d = sec_q;
      end
      `OCPWM_ADDR_MAIN: begin
        rdata_d = main_q;
      end
      `OCPWM_ADDR_CTRL: begin
        rdata_d[`OCPWM_MODE_HI:`OCPWM_MODE_LO] = mode_q;
        rdata_d[`OCPWM_TSEL_BIT] = tsel_q;
        rdata_d[`OCPWM_FLT_BIT] = fault_q;
        rdata_d[`OCPWM_SIDL_BIT] = sidl_q;
      end
      `OCPWM_ADDR_STAT: begin
        rdata_d[`OCPWM_STAT_EVT_BIT] = evt_q;
        rdata_d[`OCPWM_STAT_PIN_BIT] = pin_q;
        rdata_d[`OCPWM_STAT_ARM_BIT] = armed_q;
      end
      default: begin
        rdata_d = `OCPWM_RST_WORD;
      end
    endcase
  end

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      RDATA <= `OCPWM_RST_WORD;
    end else if (RD) begin
      RDATA <= rdata_d;
    end else begin
      RDATA <= `OCPWM_RST_WORD;
    end
  end

  // ----------------------------------------
  // main value: written directly outside pwm, reloaded in pwm
  // ----------------------------------------
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      main_q <= `OCPWM_RST_WORD;
    end else if (period_end) begin
      main_q <= sec_q;
    end else if (wr_hit(`OCPWM_ADDR_MAIN) && !is_pwm) begin
      main_q <= WDATA;
    end
  end

  // ----------------------------------------
  // pin, pulse arming and fault
  // ----------------------------------------
  always @* begin
    pin_d = pin_q;
    armed_d = armed_q;
    fault_d = fault_q;
    // fault clears only once the input is back high and the mode is rewritten
    if (ctrl_wr && FAULT_N) begin
      fault_d = 1'b0;
    end else if (run && (mode_q == `OCPWM_M_PWMF) && !FAULT_N) begin
      fault_d = 1'b1;
    end
    if (ctrl_wr) begin
      // a mode write re-arms the single pulse
      armed_d = (WDATA[`OCPWM_MODE_HI:`OCPWM_MODE_LO] == `OCPWM_M_SINGLE);
    end else if (run) begin
      case (mode_q)
        `OCPWM_M_LOW: begin
          if (match_main) pin_d = 1'b0;
        end
        `OCPWM_M_HIGH: begin
          if (match_main) pin_d = 1'b1;
        end
        `OCPWM_M_TOGGLE: begin
          if (match_main) pin_d = !pin_q;
        end
        `OCPWM_M_SINGLE: begin
          if (armed_q && match_main) begin
            pin_d = 1'b1;
          end else if (armed_q && match_sec && pin_q) begin
            pin_d = 1'b0;
            armed_d = 1'b0;
          end
        end
        `OCPWM_M_CONT: begin
          if (match_main) begin
            pin_d = 1'b1;
          end else if (match_sec) begin
            pin_d = 1'b0;
          end
        end
        `OCPWM_M_PWM, `OCPWM_M_PWMF: begin
          if (period_end) begin
            pin_d = (sec_q != `OCPWM_DUTY_ZERO);
          end else if (duty_hit) begin
            pin_d = 1'b0;
          end
        end
        default: begin
          pin_d = pin_q;
        end
      endcase
    end
  end

  // ----------------------------------------
  // pin, arming and fault state
  // ----------------------------------------
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      pin_q <= 1'b0;
      armed_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
      armed_q <= armed_d;
      fault_q <= fault_d;
    end
  end

  // ----------------------------------------
  // compare event flag, set wins over clear
  // ----------------------------------------
  always @* begin
    evt_d = evt_q;
    if (evt_hit) begin
      evt_d = 1'b1;
    end else if (evt_clr) begin
      evt_d = 1'b0;
    end
  end

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      evt_q <= 1'b0;
    end else begin
      evt_q <= evt_d;
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      OC_OUT <= 1'b0;
      OC_OE <= 1'b0;
      EVT_FLAG <= 1'b0;
      TA_PERIOD_FLAG <= 1'b0;
      TB_PERIOD_FLAG <= 1'b0;
    end else begin
      OC_OUT <= pin_q;
      OC_OE <= oe_d;
      EVT_FLAG <= evt_q;
      TA_PERIOD_FLAG <= period_end && !tsel_q;
      TB_PERIOD_FLAG <= period_end && tsel_q;
    end
  end

endmodule // ocpwm_channel

// *** verif/ocpwm_monitor.sv ***
// port checker for the compare channel
// assumes a bind onto ocpwm_channel; mode and values are tracked from bus writes
`timescale 1ns/100ps
module ocpwm_monitor (
  // watched ports
  input wire CLK, input wire RST, input wire [3:0] ADDR, input wire [15:0] WDATA, input wire WR,
  input wire [15:0] TA_COUNT, input wire [15:0] TB_COUNT, input wire TA_INC, input wire TB_INC,
  input wire SLEEP, input wire IDLE, input wire FAULT_N, input wire OC_OUT, input wire OC_OE,
  input wire EVT_FLAG, input wire TA_PERIOD_FLAG, input wire TB_PERIOD_FLAG
);
  reg [2:0] md_q;
  reg ts_q;
  reg [15:0] mv_q;
  reg [15:0] sv_q;
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      md_q <= 3'h0;
      ts_q <= 1'h0;
      mv_q <= 16'h0000;
      sv_q <= 16'h0000;
    end else if (WR) begin
      if (ADDR == 4'h2) md_q <= WDATA[2:0];
      if (ADDR == 4'h2) ts_q <= WDATA[3];
      if (ADDR == 4'h1 && md_q[2:1] != 2'h3) mv_q <= WDATA;
      if (ADDR == 4'h0) sv_q <= WDATA;
    end
  end
  wire run = (ts_q ? TB_INC : TA_INC) && !SLEEP && !IDLE && !WR;
  wire ev = run && (ts_q ? TB_COUNT : TA_COUNT) == mv_q;
  wire pwm = md_q[2:1] == 2'h3;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_asleep; SLEEP ##1 SLEEP; endsequence
  sequence s_off; md_q == 3'h0 ##1 md_q == 3'h0; endsequence
  property p_tog; ev && md_q == 3'h3 |-> ##2 OC_OUT != $past(OC_OUT, 2); endproperty
  property p_evt; ev && !md_q[2] && md_q != 3'h0 |-> ##[1:3] EVT_FLAG; endproperty
  property p_nopwm; (pwm && !EVT_FLAG) [*3] |=> !EVT_FLAG; endproperty
  property p_fault; md_q == 3'h7 && !FAULT_N && !SLEEP && !IDLE |-> ##[1:2] !OC_OE; endproperty
  property p_hold; $fell(OC_OE) && md_q == 3'h7 ##1 !WR |-> !OC_OE; endproperty
  property p_sleep; s_asleep |=> $stable(OC_OUT); endproperty
  property p_per; run && md_q == 3'h6 && !ts_q && sv_q != 16'h0000 |-> ##1 TA_PERIOD_FLAG ##1 OC_OUT; endproperty
  property p_off; s_off |-> !OC_OE; endproperty
  a_tog: assert property (p_tog) else $error("toggle missing");
  a_evt: assert property (p_evt) else $error("event flag missing");
  a_nopwm: assert property (p_nopwm) else $error("event flag in pwm");
  a_fault: assert property (p_fault) else $error("fault not tristated");
  a_hold: assert property (p_hold) else $error("fault not held");
  a_sleep: assert property (p_sleep) else $error("pin moved in sleep");
  a_per: assert property (p_per) else $error("period start wrong");
  a_off: assert property (p_off) else $error("pin driven when off");
endmodule // ocpwm_monitor

// *** verif/ocpwm_load.sv ***
// external load on the compare pin
// assumes the pin arrives as level plus drive enable
`timescale 1ns/100ps
module ocpwm_load (
  // pin side
  input wire clk,
  input wire oc_out,
  input wire oc_oe,
  // level seen by the load
  output wire pin
);
  reg last_q = 1'h0;
  always @(posedge clk) begin
    if (oc_oe) last_q <= oc_out;
  end
  // no pull on the line, so a released pin shows the opposite of its last level
  assign pin = oc_oe ? oc_out : ~last_q;
endmodule // ocpwm_load

// *** verif/testbench.sv ***
// self-checking bench for the compare channel
// assumes ocpwm_channel, ocpwm_load and ocpwm_monitor are compiled first
`timescale 1ns/100ps
module testbench;
  reg CLK = 1'h0, RST = 1'h1, WR = 1'h0, RD = 1'h0, TA_INC = 1'h0, TB_INC = 1'h0, TA_ON = 1'h1;
  reg TB_ON = 1'h1, TA_SIDL = 1'h0, TB_SIDL = 1'h0, SLEEP = 1'h0, IDLE = 1'h0, FAULT_N = 1'h1, rd_d = 1'h0;
  reg [3:0] ADDR = 4'h0;
  reg [15:0] WDATA = 16'h0000, TA_COUNT = 16'h0000, TB_COUNT = 16'h0000;
  reg [31:0] rnd = 32'h0F49C5A6;
  reg [19:0] q[$];
  reg [19:0] e;
  wire [15:0] RDATA;
  wire OC_OUT, OC_OE, EVT_FLAG, TA_PERIOD_FLAG, TB_PERIOD_FLAG, pin_lvl;
  integer err_total = 0, checks = 0;
  always #5 CLK = ~CLK;
  ocpwm_channel dut (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .TA_COUNT(TA_COUNT), .TA_INC(TA_INC), .TA_ON(TA_ON), .TA_SIDL(TA_SIDL), .TB_COUNT(TB_COUNT), .TB_INC(TB_INC),
    .TB_ON(TB_ON), .TB_SIDL(TB_SIDL), .SLEEP(SLEEP), .IDLE(IDLE), .FAULT_N(FAULT_N), .OC_OUT(OC_OUT),
    .OC_OE(OC_OE), .EVT_FLAG(EVT_FLAG), .TA_PERIOD_FLAG(TA_PERIOD_FLAG), .TB_PERIOD_FLAG(TB_PERIOD_FLAG));
  ocpwm_load load (.clk(CLK), .oc_out(OC_OUT), .oc_oe(OC_OE), .pin(pin_lvl));
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input [3:0] a, input [15:0] seen, input [15:0] x);
    checks = checks + 1;
    if (seen !== x) begin
      err_total = err_total + 1;
      $display("ERROR reg %0d expected %h seen %h", a, x, seen);
    end
  endtask
  task wr(input [3:0] a, input [15:0] d);
    ADDR <= a; WDATA <= d; WR <= 1'h1;
    @(posedge CLK) WR <= 1'h0;
    @(posedge CLK);
  endtask
  task rd(input [3:0] a, input [15:0] x);
    ADDR <= a; RD <= 1'h1; q.push_back({a, x});
    @(posedge CLK) RD <= 1'h0;
    @(posedge CLK);
  endtask
  task tick(input b, input [15:0] c);
    TA_COUNT <= c; TB_COUNT <= c; TA_INC <= !b; TB_INC <= b;
    @(posedge CLK) {TA_INC, TB_INC} <= 2'h0;
    @(posedge CLK);
  endtask
  task st(input b, input [15:0] c, input [15:0] x);
    tick(b, c);
    rd(4'h3, x);
  endtask
  task end_of_test;
    // let the last read answer be compared before the verdict
    repeat (3) @(posedge CLK);
    if (q.size() != 0) err_total = err_total + 1;
    if (err_total == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // read answers are compared one cycle after the strobe; armed bit left out
  always @(posedge CLK) begin
    rd_d <= RD;
    if (rd_d) begin
      e = q.pop_front();
      chk(e[19:16], e[19:16] == 4'h3 ? RDATA & 16'hFFFB : RDATA, e[15:0]);
    end
  end
  initial begin
    repeat (2) @(posedge CLK);
    RST <= 1'h0;
    rd(4'h2, 16'h0000);
    wr(4'h1, 16'h0010);
    wr(4'h2, 16'h0002);
    st(0, 16'h0010, 16'h0003);
    wr(4'h3, 16'h0001);
    rnd = lfsr(rnd);
    st(0, rnd[15:0] | 16'h8000, 16'h0002);
    st(0, 16'h0000, 16'h0002);
    chk(4'hF, {15'h0000, pin_lvl}, 16'h0001);
    wr(4'h2, 16'h0001);
    st(0, 16'h0010, 16'h0001);
    wr(4'h2, 16'h200B);
    rd(4'h2, 16'h200B);
    wr(4'h3, 16'h0001);
    st(0, 16'h0010, 16'h0000);
    st(1, 16'h0010, 16'h0003);
    st(1, 16'h0010, 16'h0001);
    wr(4'h1, 16'h0004);
    wr(4'h0, 16'h0008);
    wr(4'h2, 16'h0004);
    st(0, 16'h0004, 16'h0003);
    st(0, 16'h0008, 16'h0001);
    st(0, 16'h0004, 16'h0001);
    wr(4'h2, 16'h0004);
    st(0, 16'h0004, 16'h0003);
    wr(4'h2, 16'h0005);
    st(0, 16'h0008, 16'h0001);
    st(0, 16'h0004, 16'h0003);
    st(0, 16'h0008, 16'h0001);
    wr(4'h3, 16'h0001);
    wr(4'h0, 16'h0003);
    wr(4'h2, 16'h0006);
    wr(4'h1, 16'h0055);
    st(0, 16'h0009, 16'h0002);
    rd(4'h1, 16'h0003);
    TA_COUNT <= 16'h0003;
    repeat (2) @(posedge CLK);
    rd(4'h3, 16'h0000);
    wr(4'h0, 16'h0000);
    st(0, 16'h0009, 16'h0000);
    wr(4'h0, 16'hFFFF);
    st(0, 16'h0009, 16'h0002);
    wr(4'h2, 16'h0007);
    FAULT_N <= 1'h0;
    wr(4'h2, 16'h0007);
    rd(4'h2, 16'h0017);
    FAULT_N <= 1'h1;
    rd(4'h2, 16'h0017);
    wr(4'h2, 16'h0007);
    rd(4'h2, 16'h0007);
    wr(4'h2, 16'h0002);
    wr(4'h1, 16'h0020);
    st(0, 16'h0020, 16'h0003);
    wr(4'h2, 16'h2003);
    SLEEP <= 1'h1;
    tick(0, 16'h0020);
    SLEEP <= 1'h0;
    rd(4'h3, 16'h0003);
    IDLE <= 1'h1;
    st(0, 16'h0020, 16'h0003);
    wr(4'h2, 16'h0003);
    st(0, 16'h0020, 16'h0001);
    TA_ON <= 1'h0;
    st(0, 16'h0020, 16'h0001);
    TA_ON <= 1'h1;
    TA_SIDL <= 1'h1;
    st(0, 16'h0020, 16'h0001);
    end_of_test;
  end
endmodule // testbench
bind ocpwm_channel ocpwm_monitor mon (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .TA_COUNT(TA_COUNT), .TB_COUNT(TB_COUNT), .TA_INC(TA_INC), .TB_INC(TB_INC), .SLEEP(SLEEP), .IDLE(IDLE),
  .FAULT_N(FAULT_N), .OC_OUT(OC_OUT), .OC_OE(OC_OE), .EVT_FLAG(EVT_FLAG), .TA_PERIOD_FLAG(TA_PERIOD_FLAG),
  .TB_PERIOD_FLAG(TB_PERIOD_FLAG));
